// ### design/irqf_pkg.sv
// Purpose: Shared constants and carriers for the peripheral interrupt flag
//          and reset-status register bank.
// Assumes: APB with 32-bit data; register index times four is the address.
// Notes:   Every offset, bit position and reset value is named here once.

package irqf_pkg;

  // ***************************************************************
  // Bus and register map
  // ***************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // Register indices; byte address is index times four
  localparam logic [ADDR_W-1:0] IDX_IRQ_CONTROL = 12'h00B;
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 12'h00C;
  localparam logic [ADDR_W-1:0] IDX_ENABLES = 12'h08C;
  localparam logic [ADDR_W-1:0] IDX_POWER = 12'h08E;
  localparam logic [ADDR_W-1:0] IDX_EVT_STATUS = 12'h0C0;
  localparam logic [ADDR_W-1:0] IDX_EVT_MASK = 12'h0C1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = IDX_IRQ_CONTROL << 2;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = IDX_FLAGS << 2;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES = IDX_ENABLES << 2;
  localparam logic [ADDR_W-1:0] ADDR_POWER = IDX_POWER << 2;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = IDX_EVT_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = IDX_EVT_MASK << 2;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int BIT_CONV_DONE = 6;
  localparam int BIT_SERIAL_DONE = 3;
  localparam int BIT_CAPT_CMP = 2;
  localparam int BIT_PERIOD_MATCH = 1;
  localparam int BIT_WIDE_OVF = 0;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  // Implemented bits; the rest read zero and ignore writes
  localparam logic [REG_W-1:0] FLAGS_IMPL = 8'h4F;
  localparam logic [REG_W-1:0] IRQ_CONTROL_IMPL = 8'hC0;
  localparam logic [REG_W-1:0] POWER_IMPL = 8'h03;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [REG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [REG_W-1:0] ENABLES_RST = 8'h00;
  localparam logic [REG_W-1:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [REG_W-1:0] EVT_RST = 8'h00;
  localparam logic [REG_W-1:0] POWER_RST = 8'h00;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    CCP_OFF = 2'b00,
    CCP_CAPTURE = 2'b01,
    CCP_COMPARE = 2'b10,
    CCP_PWM = 2'b11
  } irqf_ccp_mode_e;

  // One-cycle event pulses from the peripherals
  typedef struct packed {
    logic conv_done;
    logic serial_done;
    logic capture;
    logic compare_match;
    logic period_match;
    logic wide_timer_overflow;
  } irqf_evt_s;

  // Reset-cause inputs from the reset controller
  typedef struct packed {
    logic brownout_evt;
    logic brownout_detector_enable;
  } irqf_rst_cause_s;

endpackage

// ### design/irqf_flag_reg.sv
// Purpose: Byte register of hardware-set flags with software write access.
// Assumes: set_vec bits are one-cycle pulses; wr_en is one cycle.
// Notes:   Hardware set wins over a software clear in the same cycle.

`timescale 1ns/1ps
`default_nettype none

module irqf_flag_reg #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] RST = 8'h00,
  parameter bit W1C = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Hardware and software access
  input wire logic [7:0] set_vec,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);

  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  // ***************************************************************
  // Per-bit next state
  // ***************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      if (IMPL[gi]) begin : g_impl
        // Write-one-to-clear or plain store, set taking priority
        assign nxt_q[gi] = set_vec[gi] |
          (W1C ? (q_ff[gi] & ~(wr_en & wr_data[gi]))
               : (wr_en ? wr_data[gi] : q_ff[gi]));
      end else begin : g_unimpl
        assign nxt_q[gi] = 1'b0;
      end
    end
  endgenerate

  // Flag storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_ff <= RST & IMPL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule

`default_nettype wire

// ### design/irqf_rst_status.sv
// Purpose: Power-on and brown-out reset status bits.
// Assumes: power_on_nrst falls only at power-on; the core reset does not
//          reach these bits, so they survive pin and watchdog resets.
// Notes:   A brown-out pulse clears its bit only with the detector enabled.

`timescale 1ns/1ps
`default_nettype none

module irqf_rst_status (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic power_on_nrst,
  // Reset cause from the reset controller
  input wire irqf_pkg::irqf_rst_cause_s cause,
  // Software access
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);

  logic power_on_ff;
  logic brownout_ff;
  logic nxt_power_on;
  logic nxt_brownout;
  logic bod_clear;

  // Power-on status is zero after power-on until software sets it
  assign nxt_power_on = wr_en ? wr_data[irqf_pkg::BIT_POWER_ON]
                              : power_on_ff;
  // Brown-out pulse clears the bit and beats a software write
  assign bod_clear = cause.brownout_evt &
                     cause.brownout_detector_enable;
  assign nxt_brownout = bod_clear ? 1'b0 :
    (wr_en ? wr_data[irqf_pkg::BIT_BROWNOUT] : brownout_ff);

  // Only power-on clears these, so later resets keep the evidence
  always_ff @(posedge clk or negedge power_on_nrst) begin
    if (!power_on_nrst) begin
      power_on_ff <= irqf_pkg::POWER_RST[irqf_pkg::BIT_POWER_ON];
      brownout_ff <= irqf_pkg::POWER_RST[irqf_pkg::BIT_BROWNOUT];
    end else begin
      power_on_ff <= nxt_power_on;
      brownout_ff <= nxt_brownout;
    end
  end

  assign q = {6'h00, power_on_ff, brownout_ff};

endmodule

`default_nettype wire

// ### design/irqf_top.sv
// Purpose: Peripheral interrupt flag register and reset-status register,
//          reached over APB, with enables and an event interrupt output.
// Assumes: Event inputs are one-cycle pulses synchronous to clk.
// Notes:   Zero-wait APB slave; read data is captured in the setup cycle.
//
// Functional notes
// - Every flag sets on its event whatever the enable bits say.
// - Flag bits 7, 5 and 4 ignore writes and read as zero.
// - Bit 6 sets on conversion done and holds until written to zero.
// - Bit 3 sets on serial transfer done and holds until cleared.
// - In capture mode bit 2 sets on a timer capture and holds.
// - In compare mode bit 2 sets on a compare match and holds.
// - A flag requests an interrupt only if enabled and periph enable set.
// - Power-control bit 1 tells power-on from pin or watchdog reset.
// - Power-control bit 0 tells brown-out from power-on reset.
// - Bit 0 is set by software; cleared later means a brown-out.
// - With the detector disabled bit 0 is not updated by hardware.
//
// Register access over APB is this design's own decision.

`timescale 1ns/1ps
`default_nettype none

module irqf_top (
  // Clock and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_on_nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irqf_pkg::ADDR_W-1:0] paddr,
  input wire logic [irqf_pkg::DATA_W-1:0] pwdata,
  output logic [irqf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral events and capture/compare mode
  input wire irqf_pkg::irqf_evt_s evt,
  input wire irqf_pkg::irqf_ccp_mode_e ccp_mode,
  // Reset cause
  input wire irqf_pkg::irqf_rst_cause_s rst_cause,
  // Interrupt outputs
  output logic periph_irq_req,
  output logic core_irq,
  output logic irq
);

  // ***************************************************************
  // APB decode
  // ***************************************************************
  logic [irqf_pkg::DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic setup_ph;
  logic access_done;
  logic wr_done;
  logic sel_flags;
  logic sel_enables;
  logic sel_irqctl;
  logic sel_power;
  logic sel_stat;
  logic sel_mask;
  logic mapped;
  logic [7:0] wdata8;
  logic [7:0] rd_mux;

  assign setup_ph = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign wr_done = access_done & pwrite;
  assign wdata8 = pwdata[7:0];
  // Full-address compare, so misaligned addresses fall out as unmapped
  assign sel_flags = (paddr == irqf_pkg::ADDR_FLAGS);
  assign sel_enables = (paddr == irqf_pkg::ADDR_ENABLES);
  assign sel_irqctl = (paddr == irqf_pkg::ADDR_IRQ_CONTROL);
  assign sel_power = (paddr == irqf_pkg::ADDR_POWER);
  assign sel_stat = (paddr == irqf_pkg::ADDR_EVT_STATUS);
  assign sel_mask = (paddr == irqf_pkg::ADDR_EVT_MASK);
  assign mapped = sel_flags | sel_enables | sel_irqctl | sel_power |
                  sel_stat | sel_mask;

  // ***************************************************************
  // Flag set events
  // ***************************************************************
  logic ccp_set;
  logic [7:0] flag_set;
  logic [7:0] flags_q;
  logic [7:0] enables_ff;
  logic [7:0] irqctl_ff;
  logic [7:0] power_q;
  logic [7:0] stat_q;
  logic [7:0] mask_ff;

  // Capture or compare sets bit 2 by mode; PWM drives nothing
  assign ccp_set =
    ((ccp_mode == irqf_pkg::CCP_CAPTURE) & evt.capture) |
    ((ccp_mode == irqf_pkg::CCP_COMPARE) & evt.compare_match);

  // Events set flags with no regard to enables
  assign flag_set = {1'b0, evt.conv_done, 2'b00, evt.serial_done,
                     ccp_set, evt.period_match,
                     evt.wide_timer_overflow};

  // Flags store writes; unimplemented bits are forced to zero
  irqf_flag_reg #(
    .IMPL(irqf_pkg::FLAGS_IMPL),
    .RST(irqf_pkg::FLAGS_RST),
    .W1C(1'b0)
  ) u_flags (
    .clk(clk),
    .nrst(nrst),
    .set_vec(flag_set),
    .wr_en(wr_done & sel_flags),
    .wr_data(wdata8),
    .q(flags_q)
  );

  // Event status: the same flag events, sticky, write one to clear
  irqf_flag_reg #(
    .IMPL(irqf_pkg::FLAGS_IMPL),
    .RST(irqf_pkg::EVT_RST),
    .W1C(1'b1)
  ) u_evt_status (
    .clk(clk),
    .nrst(nrst),
    .set_vec(flag_set),
    .wr_en(wr_done & sel_stat),
    .wr_data(wdata8),
    .q(stat_q)
  );

  // Power-on and brown-out status
  irqf_rst_status u_rst_status (
    .clk(clk),
    .power_on_nrst(power_on_nrst),
    .cause(rst_cause),
    .wr_en(wr_done & sel_power),
    .wr_data(wdata8),
    .q(power_q)
  );

  // ***************************************************************
  // Control registers
  // ***************************************************************
  logic [7:0] nxt_enables;
  logic [7:0] nxt_irqctl;
  logic [7:0] nxt_mask;

  assign nxt_enables = (wr_done & sel_enables) ?
                       (wdata8 & irqf_pkg::FLAGS_IMPL) : enables_ff;
  assign nxt_irqctl = (wr_done & sel_irqctl) ?
                      (wdata8 & irqf_pkg::IRQ_CONTROL_IMPL) : irqctl_ff;
  assign nxt_mask = (wr_done & sel_mask) ?
                    (wdata8 & irqf_pkg::FLAGS_IMPL) : mask_ff;

  // Enable, control and mask storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enables_ff <= irqf_pkg::ENABLES_RST;
      irqctl_ff <= irqf_pkg::IRQ_CONTROL_RST;
      mask_ff <= irqf_pkg::EVT_RST;
    end else begin
      enables_ff <= nxt_enables;
      irqctl_ff <= nxt_irqctl;
      mask_ff <= nxt_mask;
    end
  end

  // ***************************************************************
  // Interrupt outputs
  // ***************************************************************
  logic periph_req_ff;
  logic core_irq_ff;
  logic irq_ff;
  logic nxt_periph_req;

  // Request needs a flag, its enable and the peripheral enable
  assign nxt_periph_req = (|(flags_q & enables_ff)) &
                          irqctl_ff[irqf_pkg::BIT_PERIPH_EN];

  // Registered so every output comes from a flop; costs one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_req_ff <= 1'b0;
      core_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      periph_req_ff <= nxt_periph_req;
      core_irq_ff <= nxt_periph_req & irqctl_ff[irqf_pkg::BIT_GLOBAL_EN];
      irq_ff <= |(stat_q & mask_ff);
    end
  end

  // ***************************************************************
  // Read data and response
  // ***************************************************************
  assign rd_mux = ({8{sel_flags}} & flags_q) |
                  ({8{sel_enables}} & enables_ff) |
                  ({8{sel_irqctl}} & irqctl_ff) |
                  ({8{sel_power}} & power_q) |
                  ({8{sel_stat}} & stat_q) |
                  ({8{sel_mask}} & mask_ff);

  // Answer one cycle after setup; unmapped gives an error and zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & ~mapped;
      if (setup_ph) begin
        prdata_ff <= {24'h000000, rd_mux};
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign periph_irq_req = periph_req_ff;
  assign core_irq = core_irq_ff;
  assign irq = irq_ff;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready_ff;
  endsequence

  chk_apb_answer: assert property (s_setup |=> s_access or !psel)
    else $error("APB access not answered one cycle after setup");

  chk_conv_flag_set: assert property (evt.conv_done |=> flags_q[6])
    else $error("conversion flag not set by event");

  chk_flag_ignores_en: assert property (
    (evt.serial_done && enables_ff == 8'h00) |=> flags_q[3])
    else $error("serial flag not set while disabled");

  chk_reserved_zero: assert property (
    (flags_q & ~irqf_pkg::FLAGS_IMPL) == 8'h00)
    else $error("unimplemented flag bit reads one");

  chk_capture_set: assert property (
    (ccp_mode == irqf_pkg::CCP_CAPTURE && evt.capture) |=> flags_q[2])
    else $error("capture did not set flag");

  chk_compare_set: assert property (
    (ccp_mode == irqf_pkg::CCP_COMPARE && evt.compare_match)
    |=> flags_q[2])
    else $error("compare match did not set flag");

  chk_pwm_no_set: assert property (
    (ccp_mode == irqf_pkg::CCP_PWM && !flags_q[2] &&
     !(wr_done && sel_flags)) |=> !flags_q[2])
    else $error("PWM mode changed capture compare flag");

  chk_timer_flags: assert property (
    (evt.period_match && evt.wide_timer_overflow) |=>
    flags_q[1:0] == 2'b11 ##1 flags_q[1:0] == 2'b11
      || $past(wr_done && sel_flags))
    else $error("timer flag not set or not held");

  chk_flag_hold: assert property (
    (flags_q[6] && !(wr_done && sel_flags)) |=> flags_q[6])
    else $error("conversion flag dropped without a write");

  // Both directions of the gate, so a wrong enable bit is caught
  chk_req_gating: assert property (
    ((|(flags_q & enables_ff)) && irqctl_ff[irqf_pkg::BIT_PERIPH_EN])
    |=> periph_req_ff)
    else $error("enabled flag did not raise peripheral request");

  chk_req_blocked: assert property (
    (!(|(flags_q & enables_ff)) || !irqctl_ff[irqf_pkg::BIT_PERIPH_EN])
    |=> !periph_req_ff)
    else $error("peripheral request without an enabled flag");

  chk_brownout_clear: assert property (
    (rst_cause.brownout_evt && rst_cause.brownout_detector_enable)
    |=> !power_q[0])
    else $error("brown-out did not clear status bit");

  // Power-on reset also moves this bit, so it stops the check too
  chk_bod_disabled: assert property (
    disable iff (!nrst || !power_on_nrst)
    (!rst_cause.brownout_detector_enable && !(wr_done && sel_power))
    |=> $stable(power_q[0]))
    else $error("brown-out bit moved with detector disabled");

  chk_irq_level: assert property (
    (|(stat_q & mask_ff)) |=> irq_ff)
    else $error("masked event status did not raise irq");

endmodule

`default_nettype wire

// ### verif/test_irqf_top.sv
// Purpose: Self-checking bench for the flag and reset-status bank.
// Assumes: Zero-wait APB slave; events are one-cycle pulses.
// Notes:   Expected values follow the bit layout, never the design's reads.

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
  tests_run++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); \
  end

module test_irqf_top;
  // ***************************************************************
  // Signals and design
  // ***************************************************************
  localparam logic [11:0] A_CTL = irqf_pkg::ADDR_IRQ_CONTROL;
  localparam logic [11:0] A_FLG = irqf_pkg::ADDR_FLAGS;
  localparam logic [11:0] A_ENA = irqf_pkg::ADDR_ENABLES;
  localparam logic [11:0] A_PWR = irqf_pkg::ADDR_POWER;
  localparam logic [11:0] A_STS = irqf_pkg::ADDR_EVT_STATUS;
  localparam logic [11:0] A_MSK = irqf_pkg::ADDR_EVT_MASK;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic por_nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  irqf_pkg::irqf_evt_s evt = '0;
  irqf_pkg::irqf_ccp_mode_e ccp_mode = irqf_pkg::CCP_OFF;
  irqf_pkg::irqf_rst_cause_s rst_cause = '0;
  logic periph_irq_req;
  logic core_irq;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] ex;
  int bad_count = 0;
  int tests_run = 0;
  // Event table: pulse vector, mode, flag bit, preset value
  logic [5:0] t_ev [8] = '{6'h20, 6'h10, 6'h02, 6'h01,
                          6'h08, 6'h04, 6'h08, 6'h04};
  logic [1:0] t_md [8] = '{2'h0, 2'h0, 2'h0, 2'h0,
                          2'h1, 2'h2, 2'h3, 2'h3};
  int t_bit [8] = '{irqf_pkg::BIT_CONV_DONE, irqf_pkg::BIT_SERIAL_DONE,
                    irqf_pkg::BIT_PERIOD_MATCH, irqf_pkg::BIT_WIDE_OVF,
                    irqf_pkg::BIT_CAPT_CMP, irqf_pkg::BIT_CAPT_CMP,
                    irqf_pkg::BIT_CAPT_CMP, irqf_pkg::BIT_CAPT_CMP};
  logic [7:0] t_pre [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h04, 8'h00};

  irqf_top u_irqf_top (
    .clk(clk),
    .nrst(nrst),
    .power_on_nrst(por_nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .evt(evt),
    .ccp_mode(ccp_mode),
    .rst_cause(rst_cause),
    .periph_irq_req(periph_irq_req),
    .core_irq(core_irq),
    .irq(irq)
  );

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; ev pulses in the access cycle to race a write
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [7:0] wd, input logic [5:0] ev,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    evt <= irqf_pkg::irqf_evt_s'(ev);
    @(posedge clk);
    evt <= '0;
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps each strobe to one assignment per time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [7:0] wd);
    apb(1'b1, ad, wd, 6'h00, rdat, rerr);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] ad,
                        input logic [7:0] exv);
    apb(1'b0, ad, 8'h00, 6'h00, rdat, rerr);
    `CHK(nm, {24'h000000, exv}, rdat)
  endtask

  task automatic pulse(input logic [5:0] ev);
    evt <= irqf_pkg::irqf_evt_s'(ev);
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask

  // Reset-cause pulse: bit 1 brown-out event, bit 0 detector enable
  task automatic bo(input logic [1:0] c);
    rst_cause <= irqf_pkg::irqf_rst_cause_s'(c);
    @(posedge clk);
    rst_cause <= irqf_pkg::irqf_rst_cause_s'({1'b0, c[0]});
    @(posedge clk);
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    por_nrst <= 1'b1;
    @(posedge clk);
    rd_chk("flags rst", A_FLG, 8'h00);
    rd_chk("power rst", A_PWR, 8'h00);
    rd_chk("ctl rst", A_CTL, 8'h00);
    // Unimplemented flag bits drop writes and read zero
    wr(A_FLG, 8'hFF);
    rd_chk("flags impl", A_FLG, 8'h4F);
    wr(A_FLG, 8'h00);
    // Each event with every enable still off
    for (int i = 0; i < 8; i++) begin
      ccp_mode <= irqf_pkg::irqf_ccp_mode_e'(t_md[i]);
      wr(A_FLG, t_pre[i]);
      pulse(t_ev[i]);
      ex = t_pre[i] | ((i < 6) ? 8'(1 << t_bit[i]) : 8'h00);
      idle(4);
      rd_chk("flag set", A_FLG, ex);
      if (i < 6) begin
        rd_chk("evt status", A_STS, ex);
        wr(A_STS, ex);
        rd_chk("status w1c", A_STS, 8'h00);
      end
      wr(A_FLG, 8'h00);
      rd_chk("flag clear", A_FLG, 8'h00);
    end
    ccp_mode <= irqf_pkg::CCP_OFF;
    // Event landing with a clearing write leaves the flag set
    apb(1'b1, A_FLG, 8'h00, 6'h20, rdat, rerr);
    rd_chk("set wins", A_FLG, 8'h40);
    // Both timer events in one cycle set both bits together
    pulse(6'h03);
    rd_chk("both timers", A_FLG, 8'h43);
    wr(A_FLG, 8'h00);
    wr(A_STS, 8'h4F);
    // Masked and unmasked event interrupt
    wr(A_MSK, 8'h08);
    pulse(6'h02);
    idle(3);
    `CHK("irq masked", 1'b0, irq)
    pulse(6'h10);
    idle(3);
    `CHK("irq raised", 1'b1, irq)
    wr(A_STS, 8'h08);
    idle(3);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk("status left", A_STS, 8'h02);
    // Peripheral request needs enable bit and peripheral enable
    wr(A_FLG, 8'h00);
    wr(A_ENA, 8'h01);
    pulse(6'h01);
    idle(3);
    `CHK("preq no pe", 1'b0, periph_irq_req)
    wr(A_CTL, 8'h40);
    idle(3);
    `CHK("preq pe", 1'b1, periph_irq_req)
    `CHK("core no gie", 1'b0, core_irq)
    wr(A_CTL, 8'hC0);
    idle(3);
    `CHK("core gie", 1'b1, core_irq)
    wr(A_ENA, 8'h00);
    idle(3);
    `CHK("preq off", 1'b0, periph_irq_req)
    // Reset status: software sets, brown-out clears bit 0
    wr(A_PWR, 8'h03);
    rd_chk("power set", A_PWR, 8'h03);
    bo(2'b10);
    rd_chk("bo det off", A_PWR, 8'h03);
    bo(2'b11);
    rd_chk("bo det on", A_PWR, 8'h02);
    // Pin or watchdog reset keeps the status bits
    nrst <= 1'b0;
    idle(4);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk("power kept", A_PWR, 8'h02);
    rd_chk("flags core", A_FLG, 8'h00);
    por_nrst <= 1'b0;
    idle(4);
    por_nrst <= 1'b1;
    @(posedge clk);
    rd_chk("power por", A_PWR, 8'h00);
    // Unmapped and misaligned addresses are refused
    apb(1'b0, 12'h010, 8'h00, 6'h00, rdat, rerr);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h00000000, rdat)
    apb(1'b1, A_FLG + 12'h001, 8'h40, 6'h00, rdat, rerr);
    `CHK("misalign err", 1'b1, rerr)
    rd_chk("misalign drop", A_FLG, 8'h00);
    wrap_up();
  end
endmodule

`default_nettype wire
